// file: logic/sgp_pkg.sv
package sgp_pkg;
	localparam logic [6:0]  SLAVE_ADDR      = 7'h0b;
	localparam logic [7:0]  HOST_ADDR_BYTE  = 8'h10;
	localparam logic [7:0]  CHG_ADDR_BYTE   = 8'h12;
	localparam logic [7:0]  CMD_MFG         = 8'h00;
	localparam logic [7:0]  CMD_THRESH      = 8'h01;
	localparam logic [7:0]  CMD_BLOCK       = 8'h20;
	localparam logic [7:0]  CMD_ALARM_MSG   = 8'h16;
	localparam logic [7:0]  BLOCK_LEN       = 8'h02;
	localparam logic [15:0] SUB_DEV_TYPE    = 16'h0001;
	localparam logic [15:0] SUB_FW_REV      = 16'h0002;
	localparam logic [15:0] SUB_EDV_QUERY   = 16'h0003;
	localparam logic [15:0] SUB_SEAL        = 16'h062b;
	localparam logic [7:0]  CRC_POLY        = 8'h07;
	localparam logic [7:0]  CRC_INIT        = 8'h00;
	localparam int          CAP_MODE_BIT    = 15;
	localparam int          CHG_MODE_BIT    = 14;
	localparam int          ALARM_MODE_BIT  = 13;
	localparam int          RCA_FLAG_BIT    = 9;
	localparam logic [15:0] THRESH_RESET    = 16'h0000;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          QTR_BIT_NS      = 2500;
	localparam int          QTR_BIT_CYC     = QTR_BIT_NS / CLK_PERIOD_NS;
	localparam longint      BUSOFF_NS       = 64'd2_000_000_000;
	localparam int          BUSOFF_CYC      = int'(BUSOFF_NS / CLK_PERIOD_NS);
endpackage

// file: logic/sgp_crc8.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_crc8
	import sgp_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clr_i,
	input  wire logic       en_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] crc_o
);
	logic [7:0] crc_reg;
	logic [7:0] crc_next;

	function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction

	always_comb begin
		crc_next = crc_reg;
		if (clr_i) begin
			crc_next = CRC_INIT;
		end else if (en_i) begin
			crc_next = crc_byte(crc_reg, data_i);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			crc_reg <= CRC_INIT;
		end else begin
			crc_reg <= crc_next;
		end
	end

	assign crc_o = crc_reg;
endmodule
`default_nettype wire

// file: logic/sgp_port.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_port
	import sgp_pkg::*;
#(
	parameter int unsigned BUSOFF_CYCLES = BUSOFF_CYC,
	parameter int unsigned QTR_CYCLES    = QTR_BIT_CYC,
	parameter logic [15:0] DEVICE_TYPE   = 16'h5a5a, // arbitrary value
	parameter logic [15:0] FW_REVISION   = 16'h0100  // arbitrary value
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic        bus_clock_line_i,
	output logic             bus_clock_line_o,
	output logic             bus_clock_line_oe_o,
	input  wire logic        bus_data_line_i,
	output logic             bus_data_line_o,
	output logic             bus_data_line_oe_o,
	input  wire logic [15:0] remaining_charge_value_i,
	input  wire logic [15:0] battery_mode_word_i,
	input  wire logic [15:0] nv_threshold_i,
	input  wire logic [15:0] end_of_discharge_level_query_i,
	input  wire logic [15:0] alarm_status_i,
	input  wire logic        host_broadcast_check_enable_i,
	input  wire logic        charger_broadcast_check_enable_i,
	input  wire logic        bcast_tick_i,
	input  wire logic        chg_req_i,
	input  wire logic [7:0]  chg_cmd_i,
	input  wire logic [15:0] chg_data_i,
	output logic             chg_busy_o,
	output logic [15:0]      manufacturer_command_word_o,
	output logic [15:0]      low_capacity_threshold_o,
	output logic             capacity_mode_o,
	output logic             low_capacity_alarm_o,
	output logic             sealed_o,
	output logic             pec_error_o,
	output logic             bus_off_o
);
	typedef enum logic [2:0] {
		SL_IDLE  = 3'b000,
		SL_RX    = 3'b001,
		SL_ACK   = 3'b010,
		SL_TX    = 3'b011,
		SL_TXACK = 3'b100
	} sgp_sl_state_t;

	typedef enum logic [1:0] {
		M_IDLE  = 2'b00,
		M_START = 2'b01,
		M_BIT   = 2'b10,
		M_STOP  = 2'b11
	} sgp_m_state_t;

	// ----------------------------------------------------------------
	// line synchronisers and bus events
	// ----------------------------------------------------------------
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic       scl_prev_reg;
	logic       sda_prev_reg;
	logic       scl;
	logic       sda;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus_clock_line_i};
			sda_sync_reg <= {sda_sync_reg[0], bus_data_line_i};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign scl = scl_sync_reg[1];
	assign sda = sda_sync_reg[1];
	wire scl_rise = scl & ~scl_prev_reg;
	wire scl_fall = ~scl & scl_prev_reg;
	wire start_ev = scl & scl_prev_reg & sda_prev_reg & ~sda;
	wire stop_ev  = scl & scl_prev_reg & ~sda_prev_reg & sda;

	// ----------------------------------------------------------------
	// slave engine and registers
	// ----------------------------------------------------------------
	sgp_sl_state_t sl_state_reg, sl_state_next;
	logic [3:0]  bitcnt_reg, bitcnt_next;
	logic [7:0]  sh_reg, sh_next;
	logic [2:0]  bidx_reg, bidx_next;
	logic [1:0]  tidx_reg, tidx_next;
	logic        rd_reg, rd_next;
	logic        have_cmd_reg, have_cmd_next;
	logic        nack_reg, nack_next;
	logic        tpec_reg, tpec_next;
	logic        mack_reg, mack_next;
	logic        sda_oe_reg, sda_oe_next;
	logic        pend_reg, pend_next;
	logic        busy_reg, busy_next;
	logic        perr_reg, perr_next;
	logic        seal_reg, seal_next;
	logic        init_reg, init_next;
	logic [7:0]  cmd_reg, cmd_next;
	logic [15:0] wdat_reg, wdat_next;
	logic [15:0] mfg_reg, mfg_next;
	logic [15:0] thr_reg, thr_next;
	logic        s_crc_clr, s_crc_en;
	logic [7:0]  s_crc_data, s_crc;
	logic [15:0] rd_word;
	logic [7:0]  tx_byte;
	logic        tx_is_pec;
	logic        ack;

	sgp_crc8 u_s_crc (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.clr_i      (s_crc_clr),
		.en_i       (s_crc_en),
		.data_i     (s_crc_data),
		.crc_o      (s_crc)
	);

	always_comb begin
		rd_word = 16'h0000;
		case (cmd_reg)
			CMD_MFG, CMD_BLOCK: begin
				case (mfg_reg)
					SUB_DEV_TYPE:  rd_word = DEVICE_TYPE;
					SUB_FW_REV:    rd_word = FW_REVISION;
					SUB_EDV_QUERY: rd_word = end_of_discharge_level_query_i;
					default:       rd_word = mfg_reg;
				endcase
			end
			CMD_THRESH: rd_word = thr_reg;
			default:    rd_word = 16'h0000;
		endcase
		tx_is_pec = 1'b0;
		if (cmd_reg == CMD_BLOCK) begin
			case (tidx_reg)
				2'd0:    tx_byte = BLOCK_LEN;
				2'd1:    tx_byte = rd_word[7:0];
				2'd2:    tx_byte = rd_word[15:8];
				default: begin
					tx_byte   = s_crc;
					tx_is_pec = 1'b1;
				end
			endcase
		end else begin
			case (tidx_reg)
				2'd0:    tx_byte = rd_word[7:0];
				2'd1:    tx_byte = rd_word[15:8];
				default: begin
					tx_byte   = s_crc;
					tx_is_pec = 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		sl_state_next = sl_state_reg;
		bitcnt_next   = bitcnt_reg;
		sh_next       = sh_reg;
		bidx_next     = bidx_reg;
		tidx_next     = tidx_reg;
		rd_next       = rd_reg;
		have_cmd_next = have_cmd_reg;
		nack_next     = nack_reg;
		tpec_next     = tpec_reg;
		mack_next     = mack_reg;
		sda_oe_next   = sda_oe_reg;
		pend_next     = pend_reg;
		busy_next     = busy_reg;
		perr_next     = perr_reg;
		seal_next     = seal_reg;
		init_next     = 1'b1;
		cmd_next      = cmd_reg;
		wdat_next     = wdat_reg;
		mfg_next      = mfg_reg;
		thr_next      = thr_reg;
		s_crc_clr     = 1'b0;
		s_crc_en      = 1'b0;
		s_crc_data    = sh_reg;
		ack           = 1'b0;
		if (!init_reg) begin
			thr_next = nv_threshold_i;
		end
		if (start_ev) begin
			if (!busy_reg) begin
				s_crc_clr     = 1'b1;
				have_cmd_next = 1'b0;
				perr_next     = 1'b0;
				pend_next     = 1'b0;
			end
			busy_next     = 1'b1;
			sl_state_next = SL_RX;
			bitcnt_next   = 4'd0;
			bidx_next     = 3'd0;
			sda_oe_next   = 1'b0;
		end else if (stop_ev) begin
			busy_next     = 1'b0;
			sl_state_next = SL_IDLE;
			sda_oe_next   = 1'b0;
			pend_next     = 1'b0;
			if (pend_reg) begin
				if (cmd_reg == CMD_MFG) begin
					mfg_next  = (wdat_reg == SUB_SEAL) ? 16'h0000 : wdat_reg;
					seal_next = seal_reg | (wdat_reg == SUB_SEAL);
				end else begin
					thr_next = wdat_reg;
				end
			end
		end else if (scl_rise) begin
			case (sl_state_reg)
				SL_RX: begin
					sh_next     = {sh_reg[6:0], sda};
					bitcnt_next = bitcnt_reg + 4'd1;
				end
				SL_TX:    bitcnt_next = bitcnt_reg + 4'd1;
				SL_TXACK: mack_next = ~sda;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (sl_state_reg)
				SL_RX: begin
					if (bitcnt_reg == 4'd8) begin
						s_crc_en = 1'b1;
						case (bidx_reg)
							3'd0: begin
								rd_next = sh_reg[0];
								ack = (sh_reg[7:1] == SLAVE_ADDR) && (!sh_reg[0] || have_cmd_reg);
							end
							3'd1: begin
								cmd_next      = sh_reg;
								have_cmd_next = 1'b1;
								ack = 1'b1;
							end
							3'd2: begin
								wdat_next[7:0] = sh_reg;
								ack = 1'b1;
							end
							3'd3: begin
								wdat_next[15:8] = sh_reg;
								ack = (cmd_reg == CMD_MFG) || (cmd_reg == CMD_THRESH);
								pend_next = ack;
							end
							3'd4: begin
								s_crc_en  = 1'b0;
								ack       = pend_reg && (sh_reg == s_crc);
								pend_next = 1'b0;
								perr_next = pend_reg && (sh_reg != s_crc);
								if (ack && cmd_reg == CMD_MFG) begin
									mfg_next  = (wdat_reg == SUB_SEAL) ? 16'h0000 : wdat_reg;
									seal_next = seal_reg | (wdat_reg == SUB_SEAL);
								end else if (ack) begin
									thr_next = wdat_reg;
								end
							end
							default: ack = 1'b0;
						endcase
						nack_next     = ~ack;
						sda_oe_next   = ack;
						bidx_next     = bidx_reg + 3'd1;
						tidx_next     = 2'd0;
						sl_state_next = SL_ACK;
					end
				end
				SL_ACK, SL_TXACK: begin
					sda_oe_next = 1'b0;
					if ((sl_state_reg == SL_ACK && nack_reg) || (sl_state_reg == SL_TXACK && (!mack_reg || tpec_reg))) begin
						sl_state_next = SL_IDLE;
					end else if (rd_reg) begin
						sh_next       = tx_byte;
						sda_oe_next   = ~tx_byte[7];
						s_crc_en      = ~tx_is_pec;
						s_crc_data    = tx_byte;
						tpec_next     = tx_is_pec;
						tidx_next     = tidx_reg + 2'd1;
						bitcnt_next   = 4'd0;
						sl_state_next = SL_TX;
					end else begin
						bitcnt_next   = 4'd0;
						sl_state_next = SL_RX;
					end
				end
				SL_TX: begin
					if (bitcnt_reg == 4'd8) begin
						sda_oe_next   = 1'b0;
						sl_state_next = SL_TXACK;
					end else begin
						sh_next     = {sh_reg[6:0], 1'b0};
						sda_oe_next = ~sh_reg[6];
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sl_state_reg <= SL_IDLE;
			bitcnt_reg   <= 4'd0;
			sh_reg       <= 8'h00;
			bidx_reg     <= 3'd0;
			tidx_reg     <= 2'd0;
			rd_reg       <= 1'b0;
			have_cmd_reg <= 1'b0;
			nack_reg     <= 1'b0;
			tpec_reg     <= 1'b0;
			mack_reg     <= 1'b0;
			sda_oe_reg   <= 1'b0;
			pend_reg     <= 1'b0;
			busy_reg     <= 1'b0;
			perr_reg     <= 1'b0;
			seal_reg     <= 1'b0;
			init_reg     <= 1'b0;
			cmd_reg      <= 8'h00;
			wdat_reg     <= 16'h0000;
			mfg_reg      <= 16'h0000;
			thr_reg      <= THRESH_RESET;
		end else begin
			sl_state_reg <= sl_state_next;
			bitcnt_reg   <= bitcnt_next;
			sh_reg       <= sh_next;
			bidx_reg     <= bidx_next;
			tidx_reg     <= tidx_next;
			rd_reg       <= rd_next;
			have_cmd_reg <= have_cmd_next;
			nack_reg     <= nack_next;
			tpec_reg     <= tpec_next;
			mack_reg     <= mack_next;
			sda_oe_reg   <= sda_oe_next;
			pend_reg     <= pend_next;
			busy_reg     <= busy_next;
			perr_reg     <= perr_next;
			seal_reg     <= seal_next;
			init_reg     <= init_next;
			cmd_reg      <= cmd_next;
			wdat_reg     <= wdat_next;
			mfg_reg      <= mfg_next;
			thr_reg      <= thr_next;
		end
	end

	// ----------------------------------------------------------------
	// bus off / on detection
	// ----------------------------------------------------------------
	logic [31:0] off_cnt_reg;
	logic        off_reg;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			off_cnt_reg <= 32'h0000_0000;
			off_reg     <= 1'b0;
		end else if (!scl && !sda) begin
			if (off_cnt_reg < BUSOFF_CYCLES) begin
				off_cnt_reg <= off_cnt_reg + 32'h0000_0001;
			end else begin
				off_reg <= 1'b1;
			end
		end else begin
			off_cnt_reg <= 32'h0000_0000;
			if (scl && sda) begin
				off_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// master broadcasts
	// ----------------------------------------------------------------
	sgp_m_state_t m_state_reg, m_state_next;
	logic [31:0] qcnt_reg, qcnt_next;
	logic [1:0]  ph_reg, ph_next;
	logic [3:0]  mbit_reg, mbit_next;
	logic [2:0]  midx_reg, midx_next;
	logic [7:0]  msh_reg, msh_next;
	logic [7:0]  mdest_reg, mdest_next, mcmd_reg, mcmd_next;
	logic [15:0] mdat_reg, mdat_next;
	logic        mpec_reg, mpec_next, msrc_reg, msrc_next, mack_ok_reg, mack_ok_next;
	logic        mscl_reg, mscl_next, msda_reg, msda_next;
	logic        apend_reg, apend_next, cpend_reg, cpend_next;
	logic [7:0]  ccmd_reg, ccmd_next;
	logic [15:0] cdat_reg, cdat_next;
	logic        m_crc_clr, m_crc_en;
	logic [7:0]  m_crc, mbyte;
	logic        qtick, alarm_act;

	sgp_crc8 u_m_crc (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.clr_i      (m_crc_clr),
		.en_i       (m_crc_en),
		.data_i     (mbyte),
		.crc_o      (m_crc)
	);

	assign qtick     = (qcnt_reg == QTR_CYCLES - 1);
	assign alarm_act = (thr_reg != 16'h0000) && (remaining_charge_value_i < thr_reg);

	always_comb begin
		case (midx_next)
			3'd0:    mbyte = mdest_next;
			3'd1:    mbyte = mcmd_next;
			3'd2:    mbyte = mdat_next[7:0];
			3'd3:    mbyte = mdat_next[15:8];
			default: mbyte = m_crc;
		endcase
	end

	always_comb begin
		m_state_next = m_state_reg;
		qcnt_next    = qtick ? 32'h0000_0000 : qcnt_reg + 32'h0000_0001;
		ph_next      = ph_reg;
		mbit_next    = mbit_reg;
		midx_next    = midx_reg;
		msh_next     = msh_reg;
		mdest_next   = mdest_reg;
		mcmd_next    = mcmd_reg;
		mdat_next    = mdat_reg;
		mpec_next    = mpec_reg;
		msrc_next    = msrc_reg;
		mack_ok_next = mack_ok_reg;
		mscl_next    = mscl_reg;
		msda_next    = msda_reg;
		ccmd_next    = ccmd_reg;
		cdat_next    = cdat_reg;
		m_crc_clr    = 1'b0;
		m_crc_en     = 1'b0;
		apend_next   = apend_reg;
		cpend_next   = cpend_reg;
		if (chg_req_i && !cpend_reg && !battery_mode_word_i[CHG_MODE_BIT]) begin
			cpend_next = 1'b1;
			ccmd_next  = chg_cmd_i;
			cdat_next  = chg_data_i;
		end
		if (qtick) begin
			ph_next = ph_reg + 2'd1;
			case (m_state_reg)
				M_IDLE: begin
					ph_next = 2'd0;
					if ((apend_reg || cpend_reg) && !busy_reg && !off_reg) begin
						msrc_next    = ~apend_reg;
						mdest_next   = apend_reg ? HOST_ADDR_BYTE : CHG_ADDR_BYTE;
						mcmd_next    = apend_reg ? CMD_ALARM_MSG : ccmd_reg;
						mdat_next    = apend_reg ? (alarm_status_i | (16'h0001 << RCA_FLAG_BIT)) : cdat_reg;
						mpec_next    = apend_reg ? host_broadcast_check_enable_i
						                         : charger_broadcast_check_enable_i;
						m_crc_clr    = 1'b1;
						m_state_next = M_START;
					end
				end
				M_START: begin
					if (ph_reg == 2'd0) begin
						msda_next = 1'b1;
					end else if (ph_reg == 2'd1) begin
						mscl_next    = 1'b1;
						midx_next    = 3'd0;
						mbit_next    = 4'd0;
						msh_next     = mbyte;
						m_crc_en     = 1'b1;
						ph_next      = 2'd0;
						m_state_next = M_BIT;
					end
				end
				M_BIT: begin
					case (ph_reg)
						2'd0: msda_next = (mbit_reg == 4'd8) ? 1'b0 : ~msh_reg[7];
						2'd1: mscl_next = 1'b0;
						2'd2: mack_ok_next = ~sda;
						default: begin
							mscl_next = 1'b1;
							mbit_next = mbit_reg + 4'd1;
							msh_next  = {msh_reg[6:0], 1'b0};
							if (mbit_reg == 4'd8) begin
								if (!mack_ok_reg || midx_reg == (mpec_reg ? 3'd4 : 3'd3)) begin
									m_state_next = M_STOP;
								end else begin
									midx_next = midx_reg + 3'd1;
									mbit_next = 4'd0;
									msh_next  = mbyte;
									m_crc_en  = (midx_next != 3'd4);
								end
							end
						end
					endcase
				end
				M_STOP: begin
					case (ph_reg)
						2'd0: msda_next = 1'b1;
						2'd1: mscl_next = 1'b0;
						2'd2: msda_next = 1'b0;
						default: begin
							m_state_next = M_IDLE;
							if (msrc_reg) begin
								cpend_next = 1'b0;
							end else begin
								apend_next = 1'b0;
							end
						end
					endcase
				end
				default: m_state_next = M_IDLE;
			endcase
		end
		// a tick in the clearing cycle wins
		apend_next = apend_next | (bcast_tick_i & alarm_act & ~battery_mode_word_i[ALARM_MODE_BIT]);
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			m_state_reg <= M_IDLE;
			qcnt_reg    <= 32'h0000_0000;
			ph_reg      <= 2'd0;
			mbit_reg    <= 4'd0;
			midx_reg    <= 3'd0;
			msh_reg     <= 8'h00;
			mdest_reg   <= 8'h00;
			mcmd_reg    <= 8'h00;
			mdat_reg    <= 16'h0000;
			mpec_reg    <= 1'b0;
			msrc_reg    <= 1'b0;
			mack_ok_reg <= 1'b0;
			mscl_reg    <= 1'b0;
			msda_reg    <= 1'b0;
			apend_reg   <= 1'b0;
			cpend_reg   <= 1'b0;
			ccmd_reg    <= 8'h00;
			cdat_reg    <= 16'h0000;
		end else begin
			m_state_reg <= m_state_next;
			qcnt_reg    <= qcnt_next;
			ph_reg      <= ph_next;
			mbit_reg    <= mbit_next;
			midx_reg    <= midx_next;
			msh_reg     <= msh_next;
			mdest_reg   <= mdest_next;
			mcmd_reg    <= mcmd_next;
			mdat_reg    <= mdat_next;
			mpec_reg    <= mpec_next;
			msrc_reg    <= msrc_next;
			mack_ok_reg <= mack_ok_next;
			mscl_reg    <= mscl_next;
			msda_reg    <= msda_next;
			apend_reg   <= apend_next;
			cpend_reg   <= cpend_next;
			ccmd_reg    <= ccmd_next;
			cdat_reg    <= cdat_next;
		end
	end

	assign bus_clock_line_o            = 1'b0;
	assign bus_data_line_o             = 1'b0;
	assign bus_clock_line_oe_o         = mscl_reg;
	assign bus_data_line_oe_o          = msda_reg | sda_oe_reg;
	assign chg_busy_o                  = cpend_reg;
	assign manufacturer_command_word_o = mfg_reg;
	assign low_capacity_threshold_o    = thr_reg;
	assign capacity_mode_o             = battery_mode_word_i[CAP_MODE_BIT];
	assign low_capacity_alarm_o        = alarm_act;
	assign sealed_o                    = seal_reg;
	assign pec_error_o                 = perr_reg;
	assign bus_off_o                   = off_reg;
endmodule
`default_nettype wire

// file: verif/sgp_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_port_properties
	import sgp_pkg::*;
#(
	parameter int unsigned BUSOFF_CYCLES = BUSOFF_CYC
) (
	input wire logic        core_clk_i,
	input wire logic        rst_i,
	input wire logic        bus_clock_line_i,
	input wire logic        bus_data_line_i,
	input wire logic        bus_clock_line_oe_o,
	input wire logic [15:0] remaining_charge_value_i,
	input wire logic [15:0] battery_mode_word_i,
	input wire logic [15:0] nv_threshold_i,
	input wire logic [15:0] low_capacity_threshold_o,
	input wire logic        capacity_mode_o,
	input wire logic        low_capacity_alarm_o,
	input wire logic        sealed_o,
	input wire logic        pec_error_o,
	input wire logic        bus_off_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic        up;
	logic [31:0] low_reg;
	logic [31:0] low_next;
	assign up = bus_clock_line_i & bus_data_line_i;
	always_comb begin
		low_next = (bus_clock_line_i | bus_data_line_i) ? 32'h0000_0000 : low_reg + 1;
	end
	always_ff @(posedge core_clk_i) begin
		low_reg <= low_next;
	end
	cap_mode_a: assert property (capacity_mode_o == battery_mode_word_i[CAP_MODE_BIT])
		else $error("cap mode");
	thr_load_a: assert property ($fell(rst_i) |=> low_capacity_threshold_o == $past(nv_threshold_i))
		else $error("thr load");
	alarm_calc_a: assert property (low_capacity_alarm_o ==
		(|low_capacity_threshold_o && remaining_charge_value_i < low_capacity_threshold_o)) else $error("alarm");
	alarm_zero_a: assert property (low_capacity_threshold_o == 16'h0000 |-> !low_capacity_alarm_o)
		else $error("alarm zero");
	seal_keep_a: assert property ($rose(sealed_o) |=> sealed_o [*8])
		else $error("seal");
	off_delay_a: assert property ($rose(bus_off_o) |-> low_reg >= BUSOFF_CYCLES)
		else $error("bus off early");
	on_quick_a: assert property ($rose(up) ##0 up [*6] |-> !bus_off_o)
		else $error("bus on late");
	off_quiet_a: assert property (bus_off_o |-> !bus_clock_line_oe_o)
		else $error("master in bus off");
	cover property ($rose(sealed_o));
	cover property ($rose(pec_error_o));
	cover property ($rose(bus_off_o));
	cover property ($rose(bus_clock_line_oe_o));
endmodule
`default_nettype wire

// file: verif/sgp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_host_model (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var logic  scl_oe_o,
	output var logic  sda_oe_o
);
	localparam realtime Q = 31.25;
	initial begin
		scl_oe_o = 0;
		sda_oe_o = 0;
	end
	task automatic start();
		sda_oe_o = 0;
		#Q scl_oe_o = 0;
		#Q sda_oe_o = 1;
		#Q scl_oe_o = 1;
	endtask
	task automatic stop();
		#Q sda_oe_o = 1;
		#Q scl_oe_o = 0;
		#Q sda_oe_o = 0;
		#Q;
	endtask
	task automatic bit_io(input logic b, output logic r);
		#Q sda_oe_o = !b;
		#Q scl_oe_o = 0;
		#Q r = sda_i;
		#Q scl_oe_o = 1;
	endtask
	task automatic wb(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
		bit_io(1, ack);
		ack = !ack;
	endtask
	task automatic rb(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1, r);
			d[i] = r;
		end
		bit_io(nak, r);
	endtask
	task automatic lb(input int n, output logic [39:0] v);
		v = '0;
		@(negedge sda_i iff scl_i);
		for (int j = 0; j < n * 9; j++) begin
			@(posedge scl_i);
			if (j % 9 != 8) v = {v[38:0], sda_i};
			@(negedge scl_i);
			sda_oe_o = (j % 9 == 7);
		end
	endtask
	task automatic hold(input logic v);
		scl_oe_o = v;
		sda_oe_o = v;
	endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
	import sgp_pkg::*;
;
	localparam logic [15:0] DT = 16'h3c3c; // arbitrary
	localparam logic [15:0] FW = 16'h0203; // arbitrary
	localparam logic [7:0]  AW = {SLAVE_ADDR, 1'b0};
	logic        clk = 0, rst = 1, scl, sda, h_scl, h_sda, d_scl, d_sda, seal, perr, boff;
	logic [15:0] chg = 0, mode = 0, edv = 0, nv = 16'hf0d9, lf = 16'hf0d9, thr, mfg, sv, q[$];
	logic        tick = 0, req = 0, host_broadcast_check_enable = 0, charger_broadcast_check_enable = 0, busy;
	string       nq[$];
	event        ev;
	int          n_fail = 0, checks_done = 0, cyc = 0;
	always #5 clk = ~clk;
	assign scl = !(h_scl | d_scl);
	assign sda = !(h_sda | d_sda);
	sgp_host_model host_i (.scl_i(scl), .sda_i(sda), .scl_oe_o(h_scl), .sda_oe_o(h_sda));
	sgp_port #(.BUSOFF_CYCLES(1000), .QTR_CYCLES(4), .DEVICE_TYPE(DT), .FW_REVISION(FW)) sgp_port_i (
		.core_clk_i(clk), .rst_i(rst), .bus_clock_line_i(scl), .bus_clock_line_o(), .bus_clock_line_oe_o(d_scl),
		.bus_data_line_i(sda), .bus_data_line_o(), .bus_data_line_oe_o(d_sda), .remaining_charge_value_i(chg),
		.battery_mode_word_i(mode), .nv_threshold_i(nv), .end_of_discharge_level_query_i(edv), .alarm_status_i(mode),
		.host_broadcast_check_enable_i(host_broadcast_check_enable), .charger_broadcast_check_enable_i(charger_broadcast_check_enable), .bcast_tick_i(tick),
		.chg_req_i(req), .chg_cmd_i(edv[7:0]), .chg_data_i(chg), .chg_busy_o(busy),
		.manufacturer_command_word_o(mfg), .low_capacity_threshold_o(thr), .capacity_mode_o(),
		.low_capacity_alarm_o(), .sealed_o(seal), .pec_error_o(perr), .bus_off_o(boff));
	function automatic logic [7:0] cb(input logic [7:0] c, input logic [7:0] b);
		cb = c ^ b;
		repeat (8) cb = {cb[6:0], 1'b0} ^ (cb[7] ? CRC_POLY : 8'h00);
	endfunction
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic note(input string n, input logic [15:0] v);
		nq.push_back(n);
		q.push_back(v);
	endtask
	task automatic seen(input logic [15:0] v);
		sv = v;
		->ev;
		@(negedge clk);
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	always @(ev) chk(nq.pop_front(), sv, q.pop_front());
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic [1:0] pm);
		logic a;
		logic [4:0] k;
		logic [7:0] b [5];
		k = 0;
		b = '{AW, c, d[7:0], d[15:8], cb(cb(cb(cb(CRC_INIT, AW), c), d[7:0]), d[15:8]) ^ {7'h00, pm[1]}};
		host_i.start();
		for (int i = 0; i < (pm == 0 ? 4 : 5); i++) begin
			host_i.wb(b[i], a);
			k = {k[3:0], a};
		end
		host_i.stop();
		repeat (4) @(posedge clk);
		note("acks", pm == 2 ? 16'h001e : pm == 1 ? 16'h001f : 16'h000f);
		seen({11'h000, k});
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic blk);
		logic a;
		logic [7:0] p, n, lo, hi, x;
		p = cb(cb(cb(CRC_INIT, AW), c), AW | 8'h01);
		host_i.start();
		host_i.wb(AW, a);
		host_i.wb(c, a);
		host_i.start();
		host_i.wb(AW | 8'h01, a);
		if (blk) host_i.rb(0, n);
		host_i.rb(0, lo);
		host_i.rb(0, hi);
		host_i.rb(1, x);
		host_i.stop();
		if (blk) note("count", {8'h00, BLOCK_LEN});
		if (blk) seen({8'h00, n});
		p = blk ? cb(p, BLOCK_LEN) : p;
		note("data", e);
		seen({hi, lo});
		note("pec", {8'h00, cb(cb(p, e[7:0]), e[15:8])});
		seen({8'h00, x});
	endtask
	task automatic bc(input logic alm, input logic pe, input logic [7:0] c, input logic [15:0] d);
		logic [39:0] v;
		logic [7:0]  a;
		a = alm ? HOST_ADDR_BYTE : CHG_ADDR_BYTE;
		@(posedge clk) {tick, req} <= {alm, !alm};
		@(posedge clk) {tick, req} <= 2'b00;
		host_i.lb(pe ? 5 : 4, v);
		if (!pe) v = {v[31:0], 8'h00};
		note("dest", {a, c});
		seen(v[39:24]);
		note("word", {d[7:0], d[15:8]});
		seen(v[23:8]);
		note("bpec", {8'h00, pe ? cb(cb(cb(cb(CRC_INIT, a), c), d[7:0]), d[15:8]) : 8'h00});
		seen({8'h00, v[7:0]});
		repeat (30) @(posedge clk);
		note("busy", 0);
		seen({15'h0000, busy});
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		logic a;
		repeat (20) @(posedge clk);
		rst <= 0;
		repeat (4) @(posedge clk);
		note("load", nv);
		seen(thr);
		lf = nx(lf);
		@(posedge clk) {chg, mode, edv} <= {lf ^ 16'h00ff, lf, ~lf};
		wr(CMD_THRESH, lf, 1);
		note("thr", lf);
		seen(thr);
		rd(CMD_THRESH, lf, 0);
		wr(CMD_THRESH, ~lf, 2);
		note("perr", 1);
		seen({15'h0000, perr});
		note("thr", lf);
		seen(thr);
		$display("pec done");
		for (int i = 1; i < 4; i++) begin
			wr(CMD_MFG, 16'(i), 0);
			rd(i == 3 ? CMD_BLOCK : CMD_MFG, i == 1 ? DT : i == 2 ? FW : edv, i == 3);
		end
		$display("subcommands done");
		host_i.start();
		host_i.wb({SLAVE_ADDR ^ 7'h01, 1'b0}, a);
		host_i.stop();
		note("addr", 0);
		seen({15'h0000, a});
		wr(CMD_MFG, SUB_SEAL, 1);
		note("seal", 1);
		seen({15'h0000, seal});
		note("mfg", 0);
		seen(mfg);
		$display("seal done");
		host_i.hold(1);
		repeat (1020) @(posedge clk);
		note("off", 1);
		seen({15'h0000, boff});
		host_i.hold(0);
		repeat (8) @(posedge clk);
		note("on", 0);
		seen({15'h0000, boff});
		@(posedge clk) {chg, mode, host_broadcast_check_enable, charger_broadcast_check_enable} <= {lf >> 1, lf & 16'h9fff, lf[0], ~lf[0]};
		bc(1, lf[0], CMD_ALARM_MSG, (lf & 16'h9fff) | (16'h0001 << RCA_FLAG_BIT));
		bc(0, ~lf[0], ~lf[7:0], lf >> 1);
		$display("broadcast done");
		wr(CMD_THRESH, 0, 0);
		note("thr", 0);
		seen(thr);
		$display("bus state done");
		end_of_test();
	end
endmodule
bind sgp_port sgp_port_properties #(.BUSOFF_CYCLES(BUSOFF_CYCLES)) sgp_port_properties_i (.*);
`default_nettype wire
